// >>> inc/status_event_map.svh
`ifndef STATUS_EVENT_MAP_SVH
`define STATUS_EVENT_MAP_SVH

// Condition word bit positions inside one instrument group
`define CB_CAL_ACTIVE    0
`define CB_SETTLE_WAIT   1
`define CB_RANGE_CHANGE  2
`define CB_SWEEP_ACTIVE  3
`define CB_MEAS_ACTIVE   4
`define CB_TRIG_WAIT     5
`define CB_ARM_WAIT      6
`define CB_CORR_ACTIVE   7
`define CB_SELF_TEST     8
`define CB_ABORT         9
`define CB_PROG_RUN      14

// Bits that an instrument condition word may carry
`define INST_COND_USED   16'h43ff
// Fifteen-bit register width mask, bit 15 always zero
`define WORD_MASK        16'h7fff

// Module-level group inputs: instrument summaries
`define MOD_SWITCH_BIT   1
`define MOD_DMM_BIT      2
`define MOD_COUNTER_BIT  3

// Reset and preset values of a group
`define PTR_RESET        16'h7fff
`define NTR_RESET        16'h0000
`define ENA_RESET        16'h7fff
`define PTR_PRESET       16'h7fff
`define NTR_PRESET       16'h0000
`define ENA_PRESET       16'h0000

// Standard event flags
`define SEF_USED         8'hbd
`define SEF_RESET        8'h80
`define SEF_EN_RESET     8'h00

// Top summary byte bit positions
`define TOP_QUEUE        2
`define TOP_QUES         3
`define TOP_MAV          4
`define TOP_SEF          5
`define TOP_MSS          6
`define TOP_OPER         7
`define SRE_RESET        8'h00

`endif

// >>> inc/status_event_pkg.sv
package status_event_pkg;

    // Host query and command codes
    typedef enum logic [4:0] {
        OP_CLS,
        OP_PRESET,
        OP_RD_EVT,
        OP_RD_COND,
        OP_WR_ENA,
        OP_RD_ENA,
        OP_WR_PTR,
        OP_RD_PTR,
        OP_WR_NTR,
        OP_RD_NTR,
        OP_RD_QUES,
        OP_RD_SEF,
        OP_WR_SEF_EN,
        OP_RD_SEF_EN,
        OP_WR_SRE,
        OP_RD_SRE,
        OP_RD_TOP
    } cmd_t;

    // Group index: three instruments, then the module level
    typedef logic [1:0] grp_idx_t;

endpackage : status_event_pkg

// >>> inc/status_group_if.sv
`timescale 1ns/1ps
`default_nettype none

interface status_group_if;
    logic [15:0] cond;      // Condition word into the group
    logic        wrEna;     // Enable mask write strobe
    logic        wrPtr;     // Positive filter write strobe
    logic        wrNtr;     // Negative filter write strobe
    logic [15:0] wrData;    // Write data
    logic        rdClr;     // Event read, clears after
    logic        cls;       // Clear-status
    logic        preset;    // Status preset
    logic [15:0] condReg;   // Registered condition
    logic [15:0] evtWord;   // Sticky events
    logic [15:0] enable;    // Enable mask
    logic [15:0] ptr;       // Positive filter
    logic [15:0] ntr;       // Negative filter
    logic        summary;   // Summary to next level

    modport grp (input cond, wrEna, wrPtr, wrNtr, wrData, rdClr, cls,
                 preset, output condReg, evtWord, enable, ptr, ntr, summary);
    modport ctl (output cond, wrEna, wrPtr, wrNtr, wrData, rdClr, cls,
                 preset, input condReg, evtWord, enable, ptr, ntr, summary);
endinterface : status_group_if

`default_nettype wire

// >>> src/status_group.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_event_map.svh"

module status_group
    import status_event_pkg::*;
(
    // Clock, reset, enable
    input  wire logic    clk,
    input  wire logic    arst_n,
    input  wire logic    ce,
    // Group connection
    status_group_if.grp  g
);

    logic [15:0] condReg_ff;   // Last sampled condition
    logic [15:0] event_ff;     // Sticky event bits
    logic [15:0] enable_ff;    // Enable mask
    logic [15:0] ptr_ff;       // Positive filter
    logic [15:0] ntr_ff;       // Negative filter
    wire  [15:0] condIn;       // Masked condition
    wire  [15:0] rise;         // Zero-to-one changes
    wire  [15:0] fall;         // One-to-zero changes
    wire  [15:0] hit;          // Qualifying transitions
    wire  [15:0] evtKeep;      // Event after any clear
    wire  [15:0] nxt_event;    // Next event value

    // Bit 15 never carries a condition
    assign condIn    = g.cond & `WORD_MASK;
    assign rise      = condIn & ~condReg_ff;
    assign fall      = ~condIn & condReg_ff;
    // Either filter may pass; both gives any change
    assign hit       = (rise & ptr_ff) | (fall & ntr_ff); // [R5] [R6] [R7]
    // Clear on read or clear-status, new hit still wins
    assign evtKeep   = (g.rdClr || g.cls) ? 16'h0000 : event_ff; // [R9]
    assign nxt_event = evtKeep | hit; // [R8]

    // Condition tracks its source every cycle that ce is high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            condReg_ff <= 16'h0000;
            event_ff   <= 16'h0000;
        end else if (ce) begin
            condReg_ff <= condIn; // [R4]
            event_ff   <= nxt_event;
        end
    end

    // Masks and filters; preset beats a same-cycle write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_ff <= `ENA_RESET;
            ptr_ff    <= `PTR_RESET;
            ntr_ff    <= `NTR_RESET;
        end else if (ce) begin
            if (g.preset) begin
                enable_ff <= `ENA_PRESET; // [R23]
                ptr_ff    <= `PTR_PRESET;
                ntr_ff    <= `NTR_PRESET;
            end else begin
                if (g.wrEna) enable_ff <= g.wrData & `WORD_MASK;
                if (g.wrPtr) ptr_ff    <= g.wrData & `WORD_MASK;
                if (g.wrNtr) ntr_ff    <= g.wrData & `WORD_MASK;
            end
        end
    end

    assign g.condReg = condReg_ff;
    assign g.evtWord = event_ff;
    assign g.enable  = enable_ff;
    assign g.ptr     = ptr_ff;
    assign g.ntr     = ntr_ff;
    assign g.summary = |(event_ff & enable_ff); // [R10]

    rise_set_a: assert property (@(posedge clk) disable iff (!arst_n) // [R5]
        (ce && |(rise & ptr_ff)) |=> ((event_ff & $past(rise & ptr_ff))
                                     == $past(rise & ptr_ff)))
        else $error("rising change did not latch event");
    fall_set_a: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
        (ce && |(fall & ntr_ff)) |=> ((event_ff & $past(fall & ntr_ff))
                                     == $past(fall & ntr_ff)))
        else $error("falling change did not set event");
    read_clear_a: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
        (ce && g.rdClr && hit == 16'h0000) |=> event_ff == 16'h0000)
        else $error("event read did not clear");
    preset_val_a: assert property (@(posedge clk) disable iff (!arst_n) // [R23]
        (ce && g.preset) |=> (enable_ff == 16'h0000 && ptr_ff == 16'h7fff
                              && ntr_ff == 16'h0000))
        else $error("preset values wrong");
    top_zero_a: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
        !event_ff[15] && !condReg_ff[15])
        else $error("bit 15 not zero");

endmodule : status_group

`default_nettype wire

// >>> src/std_event_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_event_map.svh"

module std_event_reg (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // Event pulses and controls
    input  wire logic [7:0] setIn,
    input  wire logic       cls,
    input  wire logic       rdClr,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    // State out
    output logic      [7:0] flags,
    output logic      [7:0] flagEn,
    output logic            summary
);

    logic [7:0] flags_ff;     // Sticky event flags
    logic [7:0] flagEn_ff;    // Enable mask
    wire  [7:0] setUsed;      // Only defined bits latch
    wire  [7:0] nxt_flags;    // Next flag value

    // Bits 1 and 6 never latch
    assign setUsed   = setIn & `SEF_USED; // [R16]
    // No condition or filters; a new event beats the clear
    assign nxt_flags = ((cls || rdClr) ? 8'h00 : flags_ff) | setUsed; // [R15]

    // Power-on flag stands from reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_ff  <= `SEF_RESET;
            flagEn_ff <= `SEF_EN_RESET;
        end else if (ce) begin
            flags_ff <= nxt_flags;
            if (wrEn) flagEn_ff <= wrData;
        end
    end

    assign flags   = flags_ff;
    assign flagEn  = flagEn_ff;
    assign summary = |(flags_ff & flagEn_ff); // [R17]

    sef_clear_a: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
        (ce && (cls || rdClr) && setUsed == 8'h00) |=> flags_ff == 8'h00)
        else $error("flags not cleared");
    sef_unused_a: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
        (ce && !flags_ff[1] && !flags_ff[6]) |=> (!flags_ff[1] && !flags_ff[6]))
        else $error("unused flag bit set");
    en_stable_a: assert property (@(posedge clk) disable iff (!arst_n) // [R24]
        (!wrEn) |=> $stable(flagEn_ff))
        else $error("enable changed without write");

endmodule : std_event_reg

`default_nettype wire

// >>> src/status_event_hierarchy.sv
// Operation
// [R1] Condition bits 0-5 report instrument activity
// [R2] Bit 6 awaiting arm, bit 7 corr_active
// [R3] Bits 8,9,14 defined; others reserved, 15 zero
// [R4] Condition register follows activity continuously
// [R5] Positive filter passes zero-to-one changes
// [R6] Negative filter passes one-to-zero changes
// [R7] Both filters pass either direction
// [R8] Qualifying change sets sticky event bit
// [R9] Event read returns value then clears
// [R10] Summary is OR of event AND enable
// [R11] Module condition bits 1-3 take summaries
// [R12] Module group same structure, reserved bits zero
// [R13] Module summary drives summary byte bit 7
// [R14] Questionable group always cleared, bit 3 zero
// [R15] Standard flags eight bits, clear on read
// [R16] Standard flag bit assignment, 1 and 6 unused
// [R17] Standard flag summary drives bit 5
// [R18] Bit 2 shows queue not empty
// [R19] Bit 4 shows message available
// [R20] Bit 6 master summary raises service request
// [R21] Summary byte has no condition or filters
// [R22] Clear-status clears events and queues
// [R23] Preset clears enables, sets positive filters
// [R24] Enable reads leave contents unchanged
// [R25] Master summary excluded from its own sum
`timescale 1ns/1ps
`default_nettype none
`include "status_event_map.svh"

module status_event_hierarchy
    import status_event_pkg::*;
(
    // Clock, reset, enable
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic            ce,
    // Instrument condition words: 0 switch, 1 dmm, 2 counter
    input  wire logic [2:0][15:0] instCond,
    // Standard event pulses, one per flag bit
    input  wire logic [7:0]      stdEvent,
    // Message path state
    input  wire logic            queueNotEmpty,
    input  wire logic            msgAvail,
    // Host command port
    input  wire logic            cmdValid,
    input  wire cmd_t            cmdOp,
    input  wire grp_idx_t        cmdTarget,
    input  wire logic [15:0]     cmdData,
    // Host answer
    output logic                 rspValid,
    output logic [15:0]          rspData,
    // Service request and queue clear
    output logic                 srqOut,
    output logic                 queueClear
);

    // Group number of the module-level group
    localparam grp_idx_t MOD_GRP = 2'd3;

    // Decode helpers, shared by every group and the flags
    function automatic logic opIs(input logic v, input cmd_t op,
                                  input cmd_t want);
        opIs = v && (op == want);
    endfunction : opIs

    function automatic logic grpHit(input logic v, input cmd_t op,
                                    input cmd_t want, input grp_idx_t tgt,
                                    input grp_idx_t idx);
        grpHit = v && (op == want) && (tgt == idx);
    endfunction : grpHit

    function automatic logic isRead(input cmd_t op);
        case (op)
            OP_RD_EVT, OP_RD_COND, OP_RD_ENA, OP_RD_PTR, OP_RD_NTR,
            OP_RD_QUES, OP_RD_SEF, OP_RD_SEF_EN, OP_RD_SRE,
            OP_RD_TOP: isRead = 1'b1;
            default:   isRead = 1'b0;
        endcase
    endfunction : isRead

    // Global command strobes
    wire clsCmd;                  // Clear-status
    wire presetCmd;               // Status preset
    assign clsCmd    = opIs(cmdValid, cmdOp, OP_CLS);
    assign presetCmd = opIs(cmdValid, cmdOp, OP_PRESET);

    // Four groups: three instruments and the module level
    status_group_if grpIf [4] ();

    logic [3:0]       grpSum;     // Summary of each group
    logic [3:0][15:0] grpEvt;     // Event word of each group
    logic [3:0][15:0] grpCond;    // Condition word of each group
    logic [3:0][15:0] grpEna;     // Enable of each group
    logic [3:0][15:0] grpPtr;     // Positive filter of each group
    logic [3:0][15:0] grpNtr;     // Negative filter of each group
    wire  [15:0]      modCond;    // Module-level condition word

    // Module word carries only the three summaries
    assign modCond = {12'h000, grpSum[2], grpSum[1], grpSum[0], 1'b0}; // [R11] [R12]

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_grp
            // Instruments keep only defined activity bits
            if (gi < 3) begin : g_inst
                assign grpIf[gi].cond = instCond[gi] & `INST_COND_USED; // [R1] [R2] [R3]
            end else begin : g_mod
                assign grpIf[gi].cond = modCond; // [R12]
            end
            assign grpIf[gi].wrEna  = grpHit(cmdValid, cmdOp, OP_WR_ENA,
                                             cmdTarget, grp_idx_t'(gi));
            assign grpIf[gi].wrPtr  = grpHit(cmdValid, cmdOp, OP_WR_PTR,
                                             cmdTarget, grp_idx_t'(gi));
            assign grpIf[gi].wrNtr  = grpHit(cmdValid, cmdOp, OP_WR_NTR,
                                             cmdTarget, grp_idx_t'(gi));
            assign grpIf[gi].wrData = cmdData;
            // Reading the event word clears it afterwards
            assign grpIf[gi].rdClr  = grpHit(cmdValid, cmdOp, OP_RD_EVT,
                                             cmdTarget, grp_idx_t'(gi)); // [R9]
            assign grpIf[gi].cls    = clsCmd; // [R22]
            assign grpIf[gi].preset = presetCmd; // [R23]
            assign grpSum[gi]  = grpIf[gi].summary; // [R10]
            assign grpEvt[gi]  = grpIf[gi].evtWord;
            assign grpCond[gi] = grpIf[gi].condReg;
            assign grpEna[gi]  = grpIf[gi].enable;
            assign grpPtr[gi]  = grpIf[gi].ptr;
            assign grpNtr[gi]  = grpIf[gi].ntr;

            status_group u_grp (
                .clk    (clk),
                .arst_n (arst_n),
                .ce     (ce),
                .g      (grpIf[gi])
            );
        end
    endgenerate

    // Standard event flags and their enable
    wire [7:0] sefFlags;          // Flag register
    wire [7:0] sefEn;             // Flag enable
    wire       sefSum;            // Flag summary
    wire       sefRdClr;          // Flag read strobe
    wire       sefWr;             // Flag enable write

    assign sefRdClr = opIs(cmdValid, cmdOp, OP_RD_SEF); // [R15]
    assign sefWr    = opIs(cmdValid, cmdOp, OP_WR_SEF_EN);

    std_event_reg u_sef (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .setIn   (stdEvent),
        .cls     (clsCmd), // [R22]
        .rdClr   (sefRdClr),
        .wrEn    (sefWr),
        .wrData  (cmdData[7:0]),
        .flags   (sefFlags),
        .flagEn  (sefEn),
        .summary (sefSum)
    );

    // Service request enable; reads never disturb it
    logic [7:0] sre_ff;           // Service request enable
    wire        sreWr;            // Enable write strobe
    assign sreWr = opIs(cmdValid, cmdOp, OP_WR_SRE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sre_ff <= `SRE_RESET;
        end else if (ce && sreWr) begin
            sre_ff <= cmdData[7:0]; // [R24]
        end
    end

    // Summary byte built straight from summaries and flags,
    // no latching stage of its own
    wire [7:0] topBase;           // Byte without master bit
    wire       mss;               // Master summary
    wire [7:0] topByte;           // Full summary byte

    assign topBase[0]         = 1'b0; // [R18]
    assign topBase[1]         = 1'b0;
    assign topBase[`TOP_QUEUE] = queueNotEmpty; // [R18]
    assign topBase[`TOP_QUES]  = 1'b0; // [R14]
    assign topBase[`TOP_MAV]   = msgAvail; // [R19]
    assign topBase[`TOP_SEF]   = sefSum; // [R17]
    assign topBase[`TOP_MSS]   = 1'b0;
    assign topBase[`TOP_OPER]  = grpSum[MOD_GRP]; // [R13] [R21]
    // Bit 6 is zero in topBase, so it cannot feed itself back
    assign mss     = |(topBase & sre_ff); // [R20] [R25]
    assign topByte = topBase | ({7'h00, mss} << `TOP_MSS);

    // Service request from a flop to keep the pin glitch free;
    // costs one cycle of lag behind the master summary
    logic srq_ff;                 // Registered service request
    logic queueClear_ff;          // One-cycle queue clear pulse

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            srq_ff        <= 1'b0;
            queueClear_ff <= 1'b0;
        end else if (ce) begin
            srq_ff        <= mss; // [R20]
            queueClear_ff <= clsCmd; // [R22]
        end
    end

    // Answer word selection for read queries
    wire [15:0] rdWord;           // Selected read value
    wire        rdReq;            // Read query this cycle

    assign rdReq  = cmdValid && isRead(cmdOp);
    assign rdWord =
        (cmdOp == OP_RD_EVT)    ? grpEvt[cmdTarget] :
        (cmdOp == OP_RD_COND)   ? grpCond[cmdTarget] :
        (cmdOp == OP_RD_ENA)    ? grpEna[cmdTarget] :
        (cmdOp == OP_RD_PTR)    ? grpPtr[cmdTarget] :
        (cmdOp == OP_RD_NTR)    ? grpNtr[cmdTarget] :
        (cmdOp == OP_RD_SEF)    ? {8'h00, sefFlags} :
        (cmdOp == OP_RD_SEF_EN) ? {8'h00, sefEn} :
        (cmdOp == OP_RD_SRE)    ? {8'h00, sre_ff} :
        (cmdOp == OP_RD_TOP)    ? {8'h00, topByte} :
        16'h0000; // Questionable reads always zero [R14]

    // Answer registers: value taken before any clear lands
    logic        rspValid_ff;     // Answer strobe
    logic [15:0] rspData_ff;      // Answer data

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rspValid_ff <= 1'b0;
            rspData_ff  <= 16'h0000;
        end else if (ce) begin
            rspValid_ff <= rdReq;
            if (rdReq) rspData_ff <= rdWord; // [R9]
        end
    end

    assign rspValid   = rspValid_ff;
    assign rspData    = rspData_ff;
    assign srqOut     = srq_ff;
    assign queueClear = queueClear_ff;

    srq_follow_a: assert property (@(posedge clk) disable iff (!arst_n) // [R20]
        (ce && mss) |=> srq_ff)
        else $error("service request not raised");
    ques_zero_a: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
        !topByte[`TOP_QUES] && !topByte[0] && !topByte[1])
        else $error("reserved summary bit set");
    oper_bit_a: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
        (grpEvt[MOD_GRP] & grpEna[MOD_GRP]) != 16'h0000
        |-> topByte[`TOP_OPER])
        else $error("module summary missing at bit 7");
    mod_resv_a: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
        (grpCond[MOD_GRP] & 16'hfff1) == 16'h0000)
        else $error("module reserved condition bit set");
    mss_self_a: assert property (@(posedge clk) disable iff (!arst_n) // [R25]
        ((topByte & 8'hbf & sre_ff) == 8'h00) |-> !mss)
        else $error("master summary feeds itself");
    read_word_a: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
        (ce && cmdValid && cmdOp == OP_RD_EVT)
        |=> (rspValid && rspData == $past(grpEvt[cmdTarget])))
        else $error("event read answer wrong");
    queue_bit_a: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
        topByte[`TOP_QUEUE] == queueNotEmpty
        && topByte[`TOP_MAV] == msgAvail)
        else $error("queue or message bit wrong");

endmodule : status_event_hierarchy

`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model
    import status_event_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Command port toward the block
    output logic             cmdValid,
    output cmd_t             cmdOp,
    output grp_idx_t         cmdTarget,
    output logic [15:0]      cmdData,
    // Answer from the block
    input  wire logic        rspValid,
    input  wire logic [15:0] rspData
);
    // Idle port at time zero
    initial begin
        cmdValid = 1'b0;
        cmdOp = OP_RD_TOP;
        cmdTarget = 2'h0;
        cmdData = 16'h0000;
    end

    // One command, strobed for one edge; reads wait a bounded time
    task automatic xfer(input cmd_t op, input grp_idx_t t,
                        input logic [15:0] d, input logic rd,
                        output logic [15:0] q, output logic ok);
        int k;
        @(negedge clk);
        cmdValid = 1'b1;
        cmdOp = op;
        cmdTarget = t;
        cmdData = d;
        @(negedge clk);
        cmdValid = 1'b0;
        // Released data never keeps its last value
        cmdData = ~d;
        k = 0;
        while (rd && rspValid !== 1'b1 && k < 4) begin
            @(negedge clk);
            k++;
        end
        ok = (k < 4);
        q = rspData;
    endtask : xfer
endmodule : host_model

`default_nettype wire

// >>> test/status_event_hierarchy_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module status_event_hierarchy_tb_top
    import status_event_pkg::*;
;
    logic             clk = 1'b0;         // 125 MHz clock
    logic             arst_n = 1'b0;      // Async reset, active low
    logic [2:0][15:0] instCond = '0;      // Instrument conditions
    logic [7:0]       stdEvent = 8'h00;   // Standard event pulses
    logic             queueNotEmpty = 1'b0;
    logic             msgAvail = 1'b0;
    logic             cmdValid, rspValid, srqOut, queueClear;
    cmd_t             cmdOp;
    grp_idx_t         cmdTarget, t;
    logic [15:0]      cmdData, rspData, a, b, p, n;
    int               n_fail = 0;
    int               comparisons = 0;

    always #4 clk = ~clk;

    status_event_hierarchy i_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .instCond(instCond), .stdEvent(stdEvent),
        .queueNotEmpty(queueNotEmpty), .msgAvail(msgAvail),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdTarget(cmdTarget),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
        .srqOut(srqOut), .queueClear(queueClear));

    host_model i_host (.clk(clk), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdTarget(cmdTarget), .cmdData(cmdData), .rspValid(rspValid),
        .rspData(rspData));

    // Verdict and end of run
    task automatic conclude();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // Compare one value
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Command without a compare; a lost read answer ends the run
    task automatic cmd(input cmd_t op, input grp_idx_t g,
                       input logic [15:0] d, output logic [15:0] q);
        logic ok;
        i_host.xfer(op, g, d, op inside {OP_RD_EVT, OP_RD_COND, OP_RD_ENA,
            OP_RD_PTR, OP_RD_NTR, OP_RD_QUES, OP_RD_SEF, OP_RD_SEF_EN,
            OP_RD_SRE, OP_RD_TOP}, q, ok);
        if (!ok) begin
            n_fail++;
            conclude();
        end
    endtask : cmd

    // Read and compare
    task automatic rdv(input cmd_t op, input grp_idx_t g,
                       input logic [15:0] e);
        logic [15:0] q;
        cmd(op, g, 16'h0000, q);
        chk(q, e);
    endtask : rdv

    task automatic waitc(input int c);
        repeat (c) @(negedge clk);
    endtask : waitc

    // Events that the filters let through between two samples
    function automatic logic [15:0] evt(input logic [15:0] a0, b0, p0, n0);
        return ((~a0 & b0 & p0) | (a0 & ~b0 & n0)) & 16'h43ff;
    endfunction : evt

    initial begin
        void'($urandom(32'hee34));
        waitc(10);
        arst_n = 1'b1;
        // Reset values, clear-on-read flags
        rdv(OP_RD_SEF, 2'h0, 16'h0080);
        rdv(OP_RD_SEF, 2'h0, 16'h0000);
        rdv(OP_RD_PTR, 2'h0, 16'h7fff);
        rdv(OP_RD_NTR, 2'h3, 16'h0000);
        rdv(OP_RD_ENA, 2'h2, 16'h7fff);
        // Random filters and edges; first pass has both filters set
        for (int i = 0; i < 8; i++) begin
            t = grp_idx_t'($urandom_range(2));
            p = (i == 0) ? 16'h7fff : 16'($urandom) & 16'h7fff;
            n = (i == 0) ? 16'h7fff : 16'($urandom) & 16'h7fff;
            cmd(OP_WR_PTR, t, p, a);
            cmd(OP_WR_NTR, t, n, a);
            // Second pass flips every used bit
            a = 16'($urandom) & 16'h43ff;
            b = (i == 1) ? ~a & 16'h43ff : 16'($urandom) & 16'h43ff;
            instCond[t] = a;
            waitc(3);
            cmd(OP_RD_EVT, t, 16'h0000, p);
            p = (i == 0) ? 16'h7fff : p;
            cmd(OP_RD_PTR, t, 16'h0000, p);
            instCond[t] = b;
            waitc(3);
            rdv(OP_RD_COND, t, b);
            rdv(OP_RD_EVT, t, evt(a, b, p, n));
            rdv(OP_RD_EVT, t, 16'h0000);
        end
        // Preset, then a quiet hierarchy
        instCond = '0;
        cmd(OP_WR_SRE, 2'h0, 16'h0080, a);
        cmd(OP_PRESET, 2'h0, 16'h0000, a);
        rdv(OP_RD_ENA, 2'h3, 16'h0000);
        rdv(OP_RD_PTR, 2'h1, 16'h7fff);
        rdv(OP_RD_NTR, 2'h1, 16'h0000);
        rdv(OP_RD_SRE, 2'h0, 16'h0080);
        for (int g = 0; g < 4; g++) cmd(OP_RD_EVT, grp_idx_t'(g), 16'h0000, a);
        // Measurement start climbs to the service request
        cmd(OP_WR_ENA, 2'h1, 16'h0010, a);
        cmd(OP_WR_ENA, 2'h3, 16'h0004, a);
        instCond[1] = 16'h0010;
        queueNotEmpty = 1'b1;
        msgAvail = 1'b1;
        waitc(8);
        chk({15'h0, srqOut}, 16'h0001);
        rdv(OP_RD_TOP, 2'h0, 16'h00d4);
        rdv(OP_RD_QUES, 2'h1, 16'h0000);
        rdv(OP_RD_EVT, 2'h3, 16'h0004);
        waitc(3);
        chk({15'h0, srqOut}, 16'h0000);
        // Command error flag through its enable
        cmd(OP_WR_SEF_EN, 2'h0, 16'h0020, a);
        stdEvent = 8'h20;
        waitc(1);
        stdEvent = 8'h00;
        waitc(3);
        rdv(OP_RD_TOP, 2'h0, 16'h0034);
        rdv(OP_RD_SEF_EN, 2'h0, 16'h0020);
        // Clear-status empties flags and the queue
        cmd(OP_CLS, 2'h0, 16'h0000, a);
        for (int k = 0; k < 3 && queueClear !== 1'b1; k++) waitc(1);
        chk({15'h0, queueClear}, 16'h0001);
        queueNotEmpty = 1'b0;
        rdv(OP_RD_SEF, 2'h0, 16'h0000);
        conclude();
    end
endmodule : status_event_hierarchy_tb_top

`default_nettype wire
